// ### design/lpt_defs.vh
// register map, field positions, reset values and timing counts
`ifndef LPT_DEFS_VH
`define LPT_DEFS_VH
// command codes (each word register: low byte, high byte)
`define LPT_CMD_ALS_CONF   8'h00
`define LPT_CMD_AMB_HI     8'h01
`define LPT_CMD_AMB_LO     8'h02
`define LPT_CMD_PS_CONF12  8'h03
`define LPT_CMD_PS_CFG3    8'h04
`define LPT_CMD_XTALK      8'h05
`define LPT_CMD_PRX_LO     8'h06
`define LPT_CMD_PRX_HI     8'h07
`define LPT_CMD_PS_RESULT  8'h08
`define LPT_CMD_ALS_RESULT 8'h0B
`define LPT_CMD_FLAGS      8'h0D
`define LPT_CMD_ID         8'h0E
// ambient config low byte fields
`define LPT_AIT_HI         7
`define LPT_AIT_LO         5
`define LPT_APERS_HI       3
`define LPT_APERS_LO       2
`define LPT_AIEN_BIT       1
`define LPT_ASD_BIT        0
// proximity config word fields (low byte conf1, high byte conf2)
`define LPT_PPERS_HI       5
`define LPT_PPERS_LO       4
`define LPT_PSD_BIT        0
`define LPT_PINT_HI        9
`define LPT_PINT_LO        8
`define LPT_PINTT_BIT      11
// proximity config three fields
`define LPT_PFOR_BIT       3
`define LPT_PTRIG_BIT      2
`define LPT_PMS_BIT        13
// flag bits
`define LPT_F_GEST         7
`define LPT_F_PROT         6
`define LPT_F_ALO          5
`define LPT_F_AHI          4
`define LPT_F_CLOSE        1
`define LPT_F_AWAY         0
// reset values
`define LPT_RST_ALS_CONF   16'h0001
`define LPT_RST_PS_CONF12  16'h0001
`define LPT_RST_ZERO       16'h0000
`define LPT_ID_VALUE       16'h1055 // arbitrary
// timing: 40 MHz clock, base ambient period 50 ms
`define LPT_CLK_HZ         40000000
`define LPT_AIT_BASE_MS    50
`define LPT_AIT_BASE_CYC   ((`LPT_CLK_HZ / 1000) * `LPT_AIT_BASE_MS)
`define LPT_PS_PERIOD_CYC  ((`LPT_CLK_HZ / 1000) * 10)
// i2c slave address
`define LPT_I2C_ADDR       7'h60
`endif

// ### design/lpt_i2c_slave.v
// i2c slave with command-code word registers, read-word and write-word
`timescale 1ns/1ps
`include "lpt_defs.vh"
module lpt_i2c_slave (
    input  wire        mclk,     // system clock
    input  wire        rst_n,    // async reset, active low
    input  wire        scl_in,   // scl pin level
    input  wire        sda_in,   // sda pin level
    output reg         sda_oe_n, // low while pulling sda low
    output reg  [7:0]  cmd,      // current command code
    output reg         wr_lo,    // pulse: write low byte
    output reg         wr_hi,    // pulse: write high byte
    output reg  [7:0]  wr_data,  // write data byte
    output reg         rd_word,  // pulse: word read finished at cmd
    input  wire [15:0] rd_data   // word for cmd
);
    localparam S_IDLE = 3'd0, S_ADDR = 3'd1, S_CMD = 3'd2, S_DLO = 3'd3;
    localparam S_DHI = 3'd4, S_RLO = 3'd5, S_RHI = 3'd6, S_SKIP = 3'd7;
    reg [1:0] scl_s, sda_s;
    reg       scl_q, sda_q;
    reg [2:0] state;
    reg [3:0] bitc;
    reg [7:0] sh;
    reg       ack_ph, rd_mode, nack;
    reg [15:0] rd_hold;
    wire scl = scl_s[1];
    wire sda = sda_s[1];
    wire scl_rise = scl & ~scl_q;
    wire scl_fall = ~scl & scl_q;
    wire start = scl & scl_q & sda_q & ~sda;
    wire stop  = scl & scl_q & ~sda_q & sda;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s <= 2'b11;
            sda_s <= 2'b11;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_s <= {scl_s[0], scl_in};
            sda_s <= {sda_s[0], sda_in};
            scl_q <= scl;
            sda_q <= sda;
        end
    end
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_IDLE; bitc <= 4'h0; sh <= 8'h00; ack_ph <= 1'b0;
            rd_mode <= 1'b0; nack <= 1'b0; sda_oe_n <= 1'b1;
            cmd <= 8'h00; wr_lo <= 1'b0; wr_hi <= 1'b0; wr_data <= 8'h00;
            rd_word <= 1'b0; rd_hold <= 16'h0000;
        end else begin
            wr_lo <= 1'b0;
            wr_hi <= 1'b0;
            rd_word <= 1'b0;
            if (start) begin
                state <= S_ADDR; bitc <= 4'h0; ack_ph <= 1'b0;
                sda_oe_n <= 1'b1;
            end else if (stop) begin
                state <= S_IDLE; sda_oe_n <= 1'b1;
            end else if (state != S_IDLE && state != S_SKIP) begin
                if (scl_rise && !ack_ph && state < S_RLO) begin
                    sh <= {sh[6:0], sda};
                    bitc <= bitc + 4'h1;
                end else if (scl_rise && ack_ph && rd_mode) begin
                    nack <= sda;
                end else if (scl_fall && !ack_ph && bitc == 4'h8) begin
                    ack_ph <= 1'b1;
                    bitc <= 4'h0;
                    case (state)
                        S_ADDR: begin
                            if (sh[7:1] == `LPT_I2C_ADDR) begin
                                sda_oe_n <= 1'b0;
                                rd_mode <= sh[0];
                            end else begin
                                state <= S_SKIP;
                            end
                        end
                        S_CMD: begin cmd <= sh; sda_oe_n <= 1'b0; end
                        S_DLO: begin
                            wr_data <= sh; wr_lo <= 1'b1; sda_oe_n <= 1'b0;
                        end
                        S_DHI: begin
                            wr_data <= sh; wr_hi <= 1'b1; sda_oe_n <= 1'b0;
                        end
                        default: sda_oe_n <= 1'b1;
                    endcase
                end else if (scl_fall && ack_ph) begin
                    ack_ph <= 1'b0;
                    sda_oe_n <= 1'b1;
                    case (state)
                        S_ADDR: begin
                            if (rd_mode) begin
                                state <= S_RLO; rd_hold <= rd_data;
                                sda_oe_n <= rd_data[7];
                                sh <= {rd_data[6:0], 1'b0};
                                bitc <= 4'h1;
                            end else begin
                                state <= S_CMD;
                            end
                        end
                        S_CMD: state <= S_DLO;
                        S_DLO: state <= S_DHI;
                        S_RLO: begin
                            if (nack) begin
                                state <= S_SKIP;
                            end else begin
                                state <= S_RHI;
                                sda_oe_n <= rd_hold[15];
                                sh <= {rd_hold[14:8], 1'b0};
                                bitc <= 4'h1;
                            end
                        end
                        S_RHI: begin
                            rd_word <= 1'b1;
                            state <= S_SKIP;
                        end
                        default: state <= S_SKIP;
                    endcase
                end else if (scl_fall && rd_mode && bitc != 4'h8 &&
                             (state == S_RLO || state == S_RHI)) begin
                    sda_oe_n <= sh[7];
                    sh <= {sh[6:0], 1'b0};
                    bitc <= bitc + 4'h1;
                end else if (scl_fall && rd_mode && bitc == 4'h8 &&
                             (state == S_RLO || state == S_RHI)) begin
                    sda_oe_n <= 1'b1;
                    ack_ph <= 1'b1;
                    bitc <= 4'h0;
                end
            end
        end
    end
endmodule // lpt_i2c_slave

// ### design/lpt_top.v
// ambient/proximity threshold, persistence and interrupt logic
`timescale 1ns/1ps
`include "lpt_defs.vh"
// Overview of operation
// - ambient high and low limits are 16 bits, written as low then high byte
// - ambient irq when result above high or below low limit, if enabled
// - integration code selects 50, 100, 200, 400 or 800 ms
// - ambient irq only after 1, 2, 4 or 8 consecutive out-of-window periods
// - separate proximity high and low limits drive irq and logic output
// - proximity irq only after 1 to 4 consecutive periods above high limit
// - in forced mode each trigger write starts exactly one measurement
// - in forced mode without trigger no new proximity result appears
// - every command register reads back
// - full ambient result comes in one read word at one command code
// - cancellation value is subtracted from each raw proximity sample
// - enabled interrupt drives the single interrupt pin low
// - registers stay accessible while the interrupt pin is low
// - proximity irq select picks close, away or both events
// - in normal mode any flag going from 0 to 1 drives the pin low
// - reading the flag register clears flags and, in normal mode, releases the pin
// - logic mode: pin low on close past high, high when below low
// - logic mode pin shows proximity state only; normal mode for ambient
// - proximity between limits asserts no proximity interrupt
// - flags: 7 gesture, 6 protect, 5 amb low, 4 amb high, 1 close, 0 away
module lpt_top (
    input  wire        mclk,        // 40 MHz clock
    input  wire        rst_n,       // async reset, active low
    input  wire        scl_in,      // i2c clock pin
    input  wire        sda_in,      // i2c data pin level
    output wire        sda_oe_n,    // low pulls sda low
    output wire        int_oe_n,    // low pulls interrupt pin low
    input  wire [15:0] als_raw,     // ambient sample from converter
    input  wire        als_done,    // pulse: ambient sample ready
    input  wire [15:0] ps_raw,      // proximity sample from converter
    input  wire        ps_done,     // pulse: proximity sample ready
    input  wire        gest_ready,  // pulse: gesture data ready
    input  wire        prot_event,  // pulse: protection mode entered
    output reg         als_start,   // pulse: start ambient integration
    output reg         ps_start,    // pulse: start proximity measurement
    output wire [2:0]  ambient_integration_time_sel   // integration time code to converter
);
    wire [7:0]  cmd;
    wire        wr_lo, wr_hi, rd_word;
    wire [7:0]  wr_data;
    reg  [15:0] rd_data;
    reg  [15:0] als_conf, amb_hi_limit, amb_lo_limit, ps_conf12, ps_cfg3;
    reg  [15:0] xtalk_cancel, prx_lo_limit, prx_hi_limit, ps_result;
    reg  [15:0] ambient_light_result;
    reg  [7:0]  flags;
    reg         prox_near;
    reg  [3:0]  als_cnt;
    reg  [2:0]  ps_cnt;
    reg  [31:0] als_tmr, ps_tmr;
    reg  [31:0] als_period;
    reg  [3:0]  als_need;
    reg         trig_pend;

    lpt_i2c_slave u_i2c (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .sda_oe_n (sda_oe_n),
        .cmd      (cmd),
        .wr_lo    (wr_lo),
        .wr_hi    (wr_hi),
        .wr_data  (wr_data),
        .rd_word  (rd_word),
        .rd_data  (rd_data)
    );

    // byte-wise update of a word register
    function [15:0] put_byte;
        input [15:0] old;
        input        hi;
        input [7:0]  d;
        begin
            put_byte = hi ? {d, old[7:0]} : {old[15:8], d};
        end
    endfunction

    wire wr_any = wr_lo | wr_hi;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            als_conf  <= `LPT_RST_ALS_CONF;
            amb_hi_limit <= `LPT_RST_ZERO;
            amb_lo_limit <= `LPT_RST_ZERO;
            ps_conf12 <= `LPT_RST_PS_CONF12;
            ps_cfg3   <= `LPT_RST_ZERO;
            xtalk_cancel <= `LPT_RST_ZERO;
            prx_lo_limit <= `LPT_RST_ZERO;
            prx_hi_limit <= `LPT_RST_ZERO;
        end else if (wr_any) begin
            case (cmd)
                `LPT_CMD_ALS_CONF:
                    als_conf <= put_byte(als_conf, wr_hi, wr_data);
                `LPT_CMD_AMB_HI:
                    amb_hi_limit <= put_byte(amb_hi_limit, wr_hi, wr_data);
                `LPT_CMD_AMB_LO:
                    amb_lo_limit <= put_byte(amb_lo_limit, wr_hi, wr_data);
                `LPT_CMD_PS_CONF12:
                    ps_conf12 <= put_byte(ps_conf12, wr_hi, wr_data);
                `LPT_CMD_PS_CFG3: // trigger bit self-clears
                    ps_cfg3 <= put_byte(ps_cfg3, wr_hi, wr_data) &
                               ~(16'h0001 << `LPT_PTRIG_BIT);
                `LPT_CMD_XTALK:
                    xtalk_cancel <= put_byte(xtalk_cancel, wr_hi, wr_data);
                `LPT_CMD_PRX_LO:
                    prx_lo_limit <= put_byte(prx_lo_limit, wr_hi, wr_data);
                `LPT_CMD_PRX_HI:
                    prx_hi_limit <= put_byte(prx_hi_limit, wr_hi, wr_data);
                default: ;
            endcase
        end
    end

    // readback of every command register
    always @* begin
        case (cmd)
            `LPT_CMD_ALS_CONF:   rd_data = als_conf;
            `LPT_CMD_AMB_HI:     rd_data = amb_hi_limit;
            `LPT_CMD_AMB_LO:     rd_data = amb_lo_limit;
            `LPT_CMD_PS_CONF12:  rd_data = ps_conf12;
            `LPT_CMD_PS_CFG3:    rd_data = ps_cfg3;
            `LPT_CMD_XTALK:      rd_data = xtalk_cancel;
            `LPT_CMD_PRX_LO:     rd_data = prx_lo_limit;
            `LPT_CMD_PRX_HI:     rd_data = prx_hi_limit;
            `LPT_CMD_PS_RESULT:  rd_data = ps_result;
            `LPT_CMD_ALS_RESULT: rd_data = ambient_light_result;
            `LPT_CMD_FLAGS:      rd_data = {flags, 8'h00};
            `LPT_CMD_ID:         rd_data = `LPT_ID_VALUE; // arbitrary value
            default:             rd_data = 16'h0000;
        endcase
    end

    wire [2:0] it_code  = als_conf[`LPT_AIT_HI:`LPT_AIT_LO];
    wire [1:0] a_pers   = als_conf[`LPT_APERS_HI:`LPT_APERS_LO];
    wire       als_ien  = als_conf[`LPT_AIEN_BIT];
    wire       als_off  = als_conf[`LPT_ASD_BIT];
    wire [1:0] p_pers   = ps_conf12[`LPT_PPERS_HI:`LPT_PPERS_LO];
    wire       ps_off   = ps_conf12[`LPT_PSD_BIT];
    wire [1:0] p_int    = ps_conf12[`LPT_PINT_HI:`LPT_PINT_LO];
    wire       p_window = ps_conf12[`LPT_PINTT_BIT];
    wire       p_forced = ps_cfg3[`LPT_PFOR_BIT];
    wire       p_logic  = ps_cfg3[`LPT_PMS_BIT];
    assign ambient_integration_time_sel = it_code;

    always @* begin
        case (it_code)
            3'b000:  als_period = `LPT_AIT_BASE_CYC;
            3'b001:  als_period = 2 * `LPT_AIT_BASE_CYC;
            3'b010:  als_period = 4 * `LPT_AIT_BASE_CYC;
            3'b100:  als_period = 8 * `LPT_AIT_BASE_CYC;
            3'b011:  als_period = 4 * `LPT_AIT_BASE_CYC;
            default: als_period = 16 * `LPT_AIT_BASE_CYC;
        endcase
        case (a_pers)
            2'd0:    als_need = 4'd1;
            2'd1:    als_need = 4'd2;
            2'd2:    als_need = 4'd4;
            default: als_need = 4'd8;
        endcase
    end

    // measurement scheduling; forced mode only on a trigger write
    wire trig_wr = wr_lo && cmd == `LPT_CMD_PS_CFG3 &&
                   wr_data[`LPT_PTRIG_BIT];
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            als_tmr <= 32'h0000_0000; ps_tmr <= 32'h0000_0000;
            als_start <= 1'b0; ps_start <= 1'b0; trig_pend <= 1'b0;
        end else begin
            als_start <= 1'b0;
            ps_start  <= 1'b0;
            if (als_off || als_tmr + 32'h0000_0001 >= als_period) begin
                als_tmr <= 32'h0000_0000;
                als_start <= ~als_off;
            end else begin
                als_tmr <= als_tmr + 32'h0000_0001;
            end
            if (trig_wr && p_forced)
                trig_pend <= 1'b1;
            if (p_forced) begin
                ps_tmr <= 32'h0000_0000;
                if (trig_pend && !ps_off) begin
                    ps_start <= 1'b1;
                    trig_pend <= 1'b0;
                end
            end else if (ps_off ||
                         ps_tmr + 32'h0000_0001 >= `LPT_PS_PERIOD_CYC) begin
                ps_tmr <= 32'h0000_0000;
                ps_start <= ~ps_off;
            end else begin
                ps_tmr <= ps_tmr + 32'h0000_0001;
            end
        end
    end

    // cancellation saturates at zero so a small sample never wraps high
    wire [15:0] ps_cancelled = (ps_raw > xtalk_cancel) ? ps_raw - xtalk_cancel
                                                       : 16'h0000;
    wire a_hi = als_raw > amb_hi_limit;
    wire a_lo = als_raw < amb_lo_limit;
    wire p_hi = ps_cancelled > prx_hi_limit;
    wire p_lo = ps_cancelled < prx_lo_limit;
    wire [3:0] als_cnt_n = als_cnt + 4'd1;
    wire [2:0] ps_cnt_n  = ps_cnt + 3'd1;
    wire als_fire = als_done && (a_hi || a_lo) && als_cnt_n >= als_need;
    wire close_ok = ps_done && p_hi && ps_cnt_n >= {1'b0, p_pers} + 3'd1;
    wire away_ok  = ps_done && p_lo && prox_near && p_window;
    wire [7:0] set_v = {gest_ready, prot_event,
                        als_fire && als_ien && a_lo,
                        als_fire && als_ien && a_hi, 2'b00,
                        close_ok && p_int[0] && !prox_near,
                        away_ok && p_int[1]};
    wire rd_flags = rd_word && cmd == `LPT_CMD_FLAGS;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ambient_light_result <= 16'h0000; ps_result <= 16'h0000;
            als_cnt <= 4'h0; ps_cnt <= 3'h0;
            prox_near <= 1'b0; flags <= 8'h00;
        end else begin
            if (als_done) begin
                ambient_light_result <= als_raw;
                if (!(a_hi || a_lo))
                    als_cnt <= 4'h0;
                else if (als_cnt_n < als_need)
                    als_cnt <= als_cnt_n;
            end
            if (ps_done) begin
                ps_result <= ps_cancelled;
                if (!p_hi)
                    ps_cnt <= 3'h0;
                else if (ps_cnt_n <= {1'b0, p_pers})
                    ps_cnt <= ps_cnt_n;
                if (close_ok)
                    prox_near <= 1'b1;
                else if (p_lo || (!p_window && !p_hi))
                    prox_near <= 1'b0;
            end
            // set wins over the read clear
            flags <= (rd_flags ? 8'h00 : flags) | set_v;
        end
    end

    // pin: logic output shows proximity state only, else any pending flag
    assign int_oe_n = p_logic ? ~prox_near
                              : ~(|flags);
endmodule // lpt_top

// ### verif/lpt_top_asserts.sv
// port-level checks for the threshold and interrupt block
`timescale 1ns/1ps
module lpt_top_asserts (
    input wire       mclk,       // 40 MHz clock
    input wire       rst_n,      // async reset, active low
    input wire       scl_in,     // i2c clock pin
    input wire       sda_oe_n,   // low pulls sda
    input wire       int_oe_n,   // low pulls irq pin
    input wire       als_done,   // ambient sample pulse
    input wire       ps_done,    // proximity sample pulse
    input wire       gest_ready, // gesture event pulse
    input wire       prot_event, // protection event pulse
    input wire       ps_start,   // measurement start pulse
    input wire [2:0] ambient_integration_time_sel  // integration code
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    reg [7:0] scl_seen; // scl high in any of the last 8 cycles
    reg       ev_d;     // any sample or event pulse last cycle
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            scl_seen <= 8'h00;
            ev_d     <= 1'b0;
        end else begin
            scl_seen <= {scl_seen[6:0], scl_in};
            ev_d     <= als_done | ps_done | gest_ready | prot_event;
        end
    end
    a_pin_fall_cause: assert property ($fell(int_oe_n) |-> ev_d)
        else $error("irq pin fell without a sample or event");
    // only a bus transfer (flag read or mode write) or a proximity sample in logic mode lets the pin go
    a_pin_rise_cause: assert property ($rose(int_oe_n) |->
        $past(ps_done) || (|scl_seen))
        else $error("irq pin rose without a read or sample");
    a_low_holds: assert property ($fell(int_oe_n) |->
        (!int_oe_n)[*8]) else $error("irq pin did not hold low");
    a_ps_start_once: assert property (ps_start |=>
        (!ps_start)[*8]) else $error("second measurement start");
    a_it_sel_on_bus: assert property (!$stable(ambient_integration_time_sel) |->
        |scl_seen) else $error("integration code moved without a write");
    a_sda_scl_low: assert property (!$stable(sda_oe_n) |->
        !scl_in && !$past(scl_in)) else $error("sda moved while scl high");
    a_gest_pin: assert property (gest_ready |=> !int_oe_n)
        else $error("gesture event did not pull the pin");
    a_prot_pin: assert property (prot_event |=> !int_oe_n)
        else $error("protection event did not pull the pin");
    c_start: cover property (ps_start);
    c_fall: cover property ($fell(int_oe_n));
    c_rise: cover property ($rose(int_oe_n));
endmodule // lpt_top_asserts
bind lpt_top lpt_top_asserts u_chk (.mclk(mclk), .rst_n(rst_n),
    .scl_in(scl_in), .sda_oe_n(sda_oe_n), .int_oe_n(int_oe_n),
    .als_done(als_done), .ps_done(ps_done), .gest_ready(gest_ready),
    .prot_event(prot_event), .ps_start(ps_start), .ambient_integration_time_sel(ambient_integration_time_sel));

// ### verif/lpt_host_model.sv
// i2c host model: word writes and read words, scl idle high
`timescale 1ns/1ps
`include "lpt_defs.vh"
module lpt_host_model (
    input  wire mclk,     // bench clock
    input  wire sda_line, // resolved sda level
    output reg  scl,      // scl drive, idles high
    output reg  sda_drv   // 0 pulls sda low
);
    integer naks;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
        naks = 0;
    end
    task w(input integer n);
        repeat (n) @(posedge mclk);
    endtask
    // short high, long low: the device answers 3-4 cycles after a fall
    task bit_io(input b, output r);
        sda_drv <= b;
        w(1);
        scl <= 1'b1;
        w(1);
        r = sda_line;
        w(1);
        scl <= 1'b0;
        w(5);
    endtask
    task xfer(input [7:0] d, input ab, output [7:0] r, output a);
        integer i;
        for (i = 7; i >= 0; i = i - 1) bit_io(d[i], r[i]);
        bit_io(ab, a);
    endtask
    task start;
        sda_drv <= 1'b1;
        w(2);
        scl <= 1'b1;
        w(2);
        sda_drv <= 1'b0;
        w(2);
        scl <= 1'b0;
        w(4);
    endtask
    task stop;
        sda_drv <= 1'b0;
        w(2);
        scl <= 1'b1;
        w(2);
        sda_drv <= 1'b1;
        w(4);
    endtask
    task wr_word(input [7:0] c, input [15:0] v);
        reg [7:0] r;
        reg [3:0] a;
        start;
        xfer({`LPT_I2C_ADDR, 1'b0}, 1'b1, r, a[0]);
        xfer(c, 1'b1, r, a[1]);
        xfer(v[7:0], 1'b1, r, a[2]);
        xfer(v[15:8], 1'b1, r, a[3]);
        stop;
        if (a !== 4'h0) naks = naks + 1;
    endtask
    task rd_word(input [7:0] c, output [15:0] v);
        reg [7:0] r;
        reg [3:0] a;
        start;
        xfer({`LPT_I2C_ADDR, 1'b0}, 1'b1, r, a[0]);
        xfer(c, 1'b1, r, a[1]);
        start;
        xfer({`LPT_I2C_ADDR, 1'b1}, 1'b1, r, a[2]);
        xfer(8'hFF, 1'b0, v[7:0], a[3]);
        xfer(8'hFF, 1'b1, v[15:8], a[3]);
        stop;
        if (a[2:0] !== 3'h0) naks = naks + 1;
    endtask
endmodule // lpt_host_model

// ### verif/light_proximity_threshold_irq_tb.sv
// self-checking bench: host model on i2c, sample pulses from the bench
`timescale 1ns/1ps
`include "lpt_defs.vh"
module light_proximity_threshold_irq_tb;
    typedef struct packed {
        logic [7:0]  cmd;
        logic [15:0] wr;
        logic [15:0] exp;
    } lpt_row_t;
    lpt_row_t   rows [0:9];
    reg         mclk, rst_n, als_done, ps_done, gest_ready, prot_event;
    reg  [15:0] als_raw, ps_raw, rd;
    wire        scl, sda_drv, sda_oe_n, int_oe_n, ps_start;
    wire [2:0]  ambient_integration_time_sel;
    wire        sda_line = sda_drv & sda_oe_n;
    integer     failures, compares, i, n_base;
    integer     n_start = 0;
    lpt_top dut (.mclk(mclk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
        .sda_oe_n(sda_oe_n), .int_oe_n(int_oe_n), .als_raw(als_raw),
        .als_done(als_done), .ps_raw(ps_raw), .ps_done(ps_done),
        .gest_ready(gest_ready), .prot_event(prot_event),
        .als_start(), .ps_start(ps_start), .ambient_integration_time_sel(ambient_integration_time_sel));
    lpt_host_model host (.mclk(mclk), .sda_line(sda_line), .scl(scl),
        .sda_drv(sda_drv));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) if (ps_start === 1'b1) n_start <= n_start + 1;
    task chk(input string nm, input [15:0] e, input [15:0] g);
        compares = compares + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task rdchk(input [7:0] c, input [15:0] e);
        host.rd_word(c, rd);
        chk($sformatf("cmd %h", c), e, rd);
    endtask
    task pin(input e);
        chk("irq pin", {15'h0000, e}, {15'h0000, int_oe_n});
    endtask
    // samples spaced 12 cycles, like a converter far faster than real
    task samp(input ps, input [15:0] v, input integer n);
        repeat (n) begin
            @(posedge mclk);
            als_raw <= v;
            ps_raw <= v;
            als_done <= !ps;
            ps_done <= ps;
            @(posedge mclk);
            als_done <= 1'b0;
            ps_done <= 1'b0;
            repeat (10) @(posedge mclk);
        end
    endtask
    task tally_and_finish;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge mclk);
        failures = failures + 1;
        tally_and_finish;
    end
    initial begin
        {rst_n, als_done, ps_done, gest_ready, prot_event} = 5'h00;
        {als_raw, ps_raw} = 32'h0000_0000;
        {failures, compares, n_base} = 0;
        rows = '{'{8'h01, 16'h1234, 16'h1234},
            '{8'h02, 16'h0056, 16'h0056},
            '{8'h05, 16'h0010, 16'h0010},
            '{8'h06, 16'h0020, 16'h0020},
            '{8'h07, 16'h0080, 16'h0080},
            '{8'h03, 16'h0B20, 16'h0B20},
            '{8'h04, 16'h0004, 16'h0000},
            '{8'h0F, 16'hABCD, 16'h0000},
            '{8'h0E, 16'hABCD, `LPT_ID_VALUE},
            '{8'h00, 16'h0006, 16'h0006}};
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        for (i = 0; i < 8; i = i + 1) begin
            host.wr_word(8'h00, {8'h00, i[2:0], 5'b00001});
            chk("it sel", {13'h0000, i[2:0]}, {13'h0000, ambient_integration_time_sel});
        end
        for (i = 0; i < 10; i = i + 1) begin
            host.wr_word(rows[i].cmd, rows[i].wr);
            rdchk(rows[i].cmd, rows[i].exp);
        end
        samp(0, 16'h2A5C, 1);
        pin(1);
        samp(0, 16'h0100, 1);
        samp(0, 16'h2A5C, 1);
        pin(1);
        samp(0, 16'h2A5C, 1);
        pin(0);
        samp(0, 16'h0100, 1);
        pin(0);
        rdchk(8'h0B, 16'h0100);
        pin(0);
        rdchk(8'h0D, 16'h1000);
        pin(1);
        samp(0, 16'h0010, 2);
        pin(0);
        rdchk(8'h0D, 16'h2000);
        samp(1, 16'h00A0, 2);
        samp(1, 16'h0050, 1);
        samp(1, 16'h00A0, 2);
        pin(1);
        samp(1, 16'h00A0, 1);
        pin(0);
        rdchk(8'h08, 16'h0090);
        rdchk(8'h0D, 16'h0200);
        samp(1, 16'h0060, 4);
        pin(1);
        samp(1, 16'h0008, 3);
        pin(0);
        rdchk(8'h08, 16'h0000);
        rdchk(8'h0D, 16'h0100);
        host.wr_word(8'h04, 16'h0008);
        n_base = n_start;
        repeat (40) @(posedge mclk);
        chk("starts idle", 16'h0000, n_start[15:0] - n_base[15:0]);
        rdchk(8'h08, 16'h0000);
        host.wr_word(8'h04, 16'h000C);
        repeat (20) @(posedge mclk);
        chk("starts trig", 16'h0001, n_start[15:0] - n_base[15:0]);
        host.wr_word(8'h04, 16'h2000);
        samp(1, 16'h00A0, 3);
        pin(0);
        samp(1, 16'h0060, 2);
        pin(0);
        samp(1, 16'h0008, 3);
        pin(1);
        host.rd_word(8'h0D, rd);
        host.wr_word(8'h04, 16'h0000);
        @(posedge mclk);
        gest_ready <= 1'b1;
        prot_event <= 1'b1;
        @(posedge mclk);
        gest_ready <= 1'b0;
        prot_event <= 1'b0;
        repeat (10) @(posedge mclk);
        pin(0);
        rdchk(8'h0D, 16'hC000);
        pin(1);
        rst_n <= 1'b0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        pin(1);
        rdchk(8'h00, 16'h0001);
        rdchk(8'h03, 16'h0001);
        rdchk(8'h01, 16'h0000);
        chk("naks", 16'h0000, host.naks[15:0]);
        tally_and_finish;
    end
endmodule // light_proximity_threshold_irq_tb
